/* File: core/uart_buffer_irq.sv */
/*
  Buffer port, interrupt enable, interrupt identification, mode and line
  status registers of a UART with small transmit and receive FIFOs.
  Assumes an external shifter delivers received characters as one-cycle
  pulses with error flags, takes transmit characters by valid/ready, and an
  external baud generator pulses char_tick once per character time.
*/
module uart_buffer_irq #(
  parameter int DEPTH = uart_fifo_pkg::FIFO_DEPTH
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [15:0] sfr_addr,
  input  wire logic        sfr_rd,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_word,
  input  wire logic [15:0] sfr_wdata,
  output logic      [15:0] sfr_rdata_q,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_char,
  input  wire logic        rx_parity_err,
  input  wire logic        rx_framing_err,
  input  wire logic        rx_break,
  input  wire logic        char_tick,
  input  wire logic        tx_ready,
  output logic             tx_valid_q,
  output logic      [7:0]  tx_char_q,
  output logic      [15:0] divisor_q,
  output logic      [15:0] mode_q,
  output logic             irq_q
);
  localparam int CW = $clog2(DEPTH + 1);

  fifo_link_if #(.W(8), .CW(CW)) rxl ();
  fifo_link_if #(.W(8), .CW(CW)) txl ();

  byte_fifo #(.W(8), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
    .clock (clock),
    .srst  (srst),
    .link  (rxl)
  );
  byte_fifo #(.W(8), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
    .clock (clock),
    .srst  (srst),
    .link  (txl)
  );

  logic [2:0]  ier_q, ier_d;
  logic [15:0] mode_d, divisor_d, rdata_d;
  logic        ovr_q, ovr_d, par_q, par_d, frm_q, frm_d, brk_q, brk_d;
  logic        txreq_q, txreq_d, tx_empty_prev_q, ier_tx_prev_q;
  logic [2:0]  tmo_cnt_q, tmo_cnt_d;
  logic        irq_d, tx_valid_d;
  logic [7:0]  tx_char_d;
  uart_fifo_pkg::tx_state_e tx_state_q, tx_state_d;

  logic        lane_lo, lane_hi, dlab, fen, mode_flip, tx_set_ev;
  logic        thr_write, rbr_read, iir_read, lsr_read, rx_err_pend;
  logic        rx_data_pend, tmo_pend, rx_overrun;
  logic [15:0] reg_addr, iir_val, lsr_val;
  logic [7:0]  len_mask;
  logic [2:0]  src_w;
  logic [1:0]  char_len;

  // Byte-lane decode of the special function register bus
  assign reg_addr = {sfr_addr[15:1], 1'b0};
  assign lane_lo  = sfr_word || !sfr_addr[0];
  assign lane_hi  = sfr_word || sfr_addr[0];
  assign dlab     = mode_q[uart_fifo_pkg::MOD_DLAB_BIT];
  assign fen      = mode_q[uart_fifo_pkg::MOD_FEN_BIT];
  assign char_len = mode_q[uart_fifo_pkg::MOD_LEN_LSB +: 2];
  assign len_mask = 8'hff >> (2'h3 - char_len);

  // Access side effects; holding registers only with divisor select 0
  assign thr_write = sfr_wr && lane_lo && !dlab && (reg_addr == uart_fifo_pkg::BUF_ADDR);
  assign rbr_read  = sfr_rd && lane_lo && !dlab && (reg_addr == uart_fifo_pkg::BUF_ADDR);
  assign iir_read  = sfr_rd && lane_lo && (reg_addr == uart_fifo_pkg::IIR_ADDR);
  assign lsr_read  = sfr_rd && lane_lo && (reg_addr == uart_fifo_pkg::LSR_ADDR);
  assign mode_flip = sfr_wr && lane_hi && (reg_addr == uart_fifo_pkg::MOD_ADDR) &&
                     (sfr_wdata[uart_fifo_pkg::MOD_FEN_BIT] != fen);

  // FIFO hookup; non-FIFO mode shrinks each store to one holding byte
  assign rxl.cap       = fen ? CW'(DEPTH) : CW'(1);
  assign txl.cap       = fen ? CW'(DEPTH) : CW'(1);
  assign rxl.push      = rx_valid;
  assign rxl.push_data = rx_char & len_mask;
  assign rxl.pop       = rbr_read;
  assign txl.push      = thr_write;
  assign txl.push_data = sfr_wdata[7:0] & len_mask;
  assign rxl.clear = mode_flip || (sfr_wr && lane_hi && (reg_addr == uart_fifo_pkg::MOD_ADDR) &&
                     sfr_wdata[uart_fifo_pkg::MOD_RFR_BIT]);
  assign txl.clear = mode_flip || (sfr_wr && lane_hi && (reg_addr == uart_fifo_pkg::MOD_ADDR) &&
                     sfr_wdata[uart_fifo_pkg::MOD_TFR_BIT]);
  assign txl.pop   = (tx_state_q == uart_fifo_pkg::TX_IDLE) && !txl.empty;
  assign rx_overrun = rx_valid && rxl.full && !rbr_read && !rxl.clear;

  // Interrupt sources and priority, highest level first
  assign rx_err_pend  = ovr_q || par_q || frm_q || brk_q;
  assign rx_data_pend = fen ? (rxl.count >= CW'(mode_q[uart_fifo_pkg::MOD_FTL_LSB +: 2]) + CW'(1))
                            : !rxl.empty;
  assign tmo_pend     = fen && !rxl.empty && (tmo_cnt_q == 3'(uart_fifo_pkg::TIMEOUT_CHARS));
  always_comb begin
    src_w = uart_fifo_pkg::SRC_NONE;
    if (rx_err_pend && ier_q[uart_fifo_pkg::IER_ERR_BIT]) begin
      src_w = uart_fifo_pkg::SRC_RX_ERR;
    end else if (rx_data_pend && ier_q[uart_fifo_pkg::IER_RX_BIT]) begin
      src_w = uart_fifo_pkg::SRC_RX_DATA;
    end else if (tmo_pend && ier_q[uart_fifo_pkg::IER_RX_BIT]) begin
      src_w = uart_fifo_pkg::SRC_TIMEOUT;
    end else if (txreq_q && ier_q[uart_fifo_pkg::IER_TX_BIT]) begin
      src_w = uart_fifo_pkg::SRC_TX_REQ;
    end
  end
  assign iir_val = {8'h00, fen ? uart_fifo_pkg::FMD_FIFO : uart_fifo_pkg::FMD_PLAIN,
                    2'b00, src_w, src_w == uart_fifo_pkg::SRC_NONE};
  assign lsr_val = {9'h000, txl.empty && !tx_valid_q, txl.empty, brk_q, frm_q, par_q, ovr_q,
                    !rxl.empty};

  // Transmit space event: holding area drains, or enable rises while empty
  assign tx_set_ev = txl.empty && (!tx_empty_prev_q ||
                     (ier_q[uart_fifo_pkg::IER_TX_BIT] && !ier_tx_prev_q));

  // Register file next values; set wins over clear on every sticky flag
  always_comb begin
    mode_d    = mode_q;
    ier_d     = ier_q;
    divisor_d = divisor_q;
    rdata_d   = sfr_rdata_q;
    if (sfr_wr && (reg_addr == uart_fifo_pkg::MOD_ADDR)) begin
      if (lane_lo) begin
        mode_d[7:0] = sfr_wdata[7:0];
      end
      if (lane_hi) begin
        mode_d[15:8] = sfr_wdata[15:8] & uart_fifo_pkg::MOD_KEEP_MASK[15:8];
      end
    end
    if (sfr_wr && lane_lo && (reg_addr == uart_fifo_pkg::IER_ADDR)) begin
      ier_d = sfr_wdata[2:0];
    end
    if (sfr_wr && dlab && (reg_addr == uart_fifo_pkg::BUF_ADDR)) begin
      if (lane_lo) begin
        divisor_d[7:0] = sfr_wdata[7:0];
      end
      if (lane_hi) begin
        divisor_d[15:8] = sfr_wdata[15:8];
      end
    end
    if (sfr_rd) begin
      case (reg_addr)
        uart_fifo_pkg::BUF_ADDR: rdata_d = dlab ? divisor_q :
                                 {8'h00, rxl.empty ? 8'h00 : rxl.head};
        uart_fifo_pkg::IER_ADDR: rdata_d = {13'h0000, ier_q};
        uart_fifo_pkg::IIR_ADDR: rdata_d = iir_val;
        uart_fifo_pkg::MOD_ADDR: rdata_d = mode_q;
        uart_fifo_pkg::LSR_ADDR: rdata_d = lsr_val;
        default:                 rdata_d = 16'h0000;
      endcase
    end
    ovr_d   = rx_overrun || (ovr_q && !lsr_read);
    par_d   = (rxl.push && rx_parity_err) || (par_q && !lsr_read);
    frm_d   = (rxl.push && rx_framing_err) || (frm_q && !lsr_read);
    brk_d   = (rxl.push && rx_break) || (brk_q && !lsr_read);
    txreq_d = tx_set_ev || (txreq_q && !thr_write &&
              !(iir_read && (src_w == uart_fifo_pkg::SRC_TX_REQ)));
    irq_d   = (src_w != uart_fifo_pkg::SRC_NONE);
  end

  // Character timeout counter; any push, pop or clear restarts it
  always_comb begin
    tmo_cnt_d = tmo_cnt_q;
    if (!fen || rxl.empty || rxl.push || rxl.pop || rxl.clear) begin
      tmo_cnt_d = 3'h0;
    end else if (char_tick && (tmo_cnt_q != 3'(uart_fifo_pkg::TIMEOUT_CHARS))) begin
      tmo_cnt_d = tmo_cnt_q + 3'h1;
    end
  end

  // Holding to shifter hand-off, one character in flight
  always_comb begin
    tx_state_d = tx_state_q;
    tx_char_d  = tx_char_q;
    case (tx_state_q)
      uart_fifo_pkg::TX_IDLE: begin
        if (!txl.empty) begin
          tx_state_d = uart_fifo_pkg::TX_LOADED;
          tx_char_d  = txl.head;
        end
      end
      uart_fifo_pkg::TX_LOADED: begin
        if (tx_ready) begin
          tx_state_d = uart_fifo_pkg::TX_IDLE;
        end
      end
      default: tx_state_d = uart_fifo_pkg::TX_IDLE;
    endcase
    tx_valid_d = (tx_state_d == uart_fifo_pkg::TX_LOADED);
  end

  // All block state outside the two FIFOs registered here
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_q          <= uart_fifo_pkg::MOD_RESET;
      ier_q           <= uart_fifo_pkg::IER_RESET;
      divisor_q       <= uart_fifo_pkg::DIV_RESET;
      sfr_rdata_q     <= 16'h0000;
      {ovr_q, par_q, frm_q, brk_q} <= 4'h0;
      txreq_q         <= 1'b0;
      tx_empty_prev_q <= 1'b1;
      ier_tx_prev_q   <= 1'b0;
      tmo_cnt_q       <= 3'h0;
      irq_q           <= 1'b0;
      tx_state_q      <= uart_fifo_pkg::TX_IDLE;
      tx_valid_q      <= 1'b0;
      tx_char_q       <= 8'h00;
    end else begin
      mode_q          <= mode_d;
      ier_q           <= ier_d;
      divisor_q       <= divisor_d;
      sfr_rdata_q     <= rdata_d;
      {ovr_q, par_q, frm_q, brk_q} <= {ovr_d, par_d, frm_d, brk_d};
      txreq_q         <= txreq_d;
      tx_empty_prev_q <= txl.empty;
      ier_tx_prev_q   <= ier_q[uart_fifo_pkg::IER_TX_BIT];
      tmo_cnt_q       <= tmo_cnt_d;
      irq_q           <= irq_d;
      tx_state_q      <= tx_state_d;
      tx_valid_q      <= tx_valid_d;
      tx_char_q       <= tx_char_d;
    end
  end

  // Checks on the register and interrupt behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_irq_follows_src: assert property (
    (src_w != uart_fifo_pkg::SRC_NONE) |=> irq_q) else $error("irq missing for pending source");
  a_rbr_upper_zero: assert property (
    rbr_read |=> (sfr_rdata_q[15:8] == 8'h00)) else $error("receive read upper byte not zero");
  a_thr_load: assert property (
    thr_write && !txl.full && !txl.pop && !txl.clear |=> txl.count == $past(txl.count) + CW'(1))
    else $error("transmit write not stored");
  a_div_word: assert property (
    sfr_wr && sfr_word && dlab && (reg_addr == uart_fifo_pkg::BUF_ADDR) |=>
    divisor_q == $past(sfr_wdata)) else $error("divisor write lost");
  a_div_no_thr: assert property (
    sfr_wr && dlab && (reg_addr == uart_fifo_pkg::BUF_ADDR) |=> txl.count <= $past(txl.count))
    else $error("transmit loaded while divisor selected");
  a_rx_justify: assert property (
    rx_valid && (char_len == 2'h0) |-> rxl.push_data[7:5] == 3'h0)
    else $error("short character not right-justified");
  a_enable_reset: assert property (@(posedge clock) disable iff (1'b0)
    srst |=> (ier_q == 3'h0) && !irq_q) else $error("enables not cleared by reset");
  a_dlab_reset: assert property (@(posedge clock) disable iff (1'b0)
    srst |=> !dlab && (mode_q[15:14] == 2'h0)) else $error("mode not cleared by reset");
  a_err_first: assert property (
    rx_err_pend && ier_q[uart_fifo_pkg::IER_ERR_BIT] |-> src_w == uart_fifo_pkg::SRC_RX_ERR)
    else $error("receive error not top priority");
  a_lsr_clears: assert property (
    lsr_read && !rx_valid |=> !rx_err_pend) else $error("line status read left error set");
  a_trigger_code: assert property (
    fen && (rxl.count == CW'(DEPTH)) && ier_q[uart_fifo_pkg::IER_RX_BIT] && !rx_err_pend |->
    src_w == uart_fifo_pkg::SRC_RX_DATA) else $error("full receive FIFO not reported");
  a_timeout_code: assert property (
    tmo_pend && ier_q[uart_fifo_pkg::IER_RX_BIT] && !rx_err_pend && !rx_data_pend |->
    src_w == uart_fifo_pkg::SRC_TIMEOUT) else $error("timeout not reported");
  a_txreq_clear: assert property (
    thr_write && !tx_set_ev |=> !txreq_q) else $error("transmit write left request set");
  a_mode_bits: assert property (
    iir_read |=> sfr_rdata_q[7:6] == ($past(fen) ? 2'h3 : 2'h0) &&
    sfr_rdata_q[0] == ($past(src_w) == uart_fifo_pkg::SRC_NONE))
    else $error("identification mode or pending bit wrong");

  c_timeout: cover property (tmo_pend && ier_q[uart_fifo_pkg::IER_RX_BIT]);
  c_overrun: cover property (rx_overrun);
  c_tx_request: cover property (src_w == uart_fifo_pkg::SRC_TX_REQ ##1 thr_write);
  c_fifo_full: cover property (fen && rxl.full);

endmodule

/* File: shared/uart_fifo_pkg.sv */
/*
  Constants, register map, field positions and state types for the
  buffered UART register and interrupt block.
  Assumes the special-function-register bus presents byte or word accesses
  at the byte addresses listed here, word accesses at even addresses.
*/
package uart_fifo_pkg;

  // Register byte addresses
  localparam logic [15:0] BUF_ADDR = 16'hf7c0;
  localparam logic [15:0] IER_ADDR = 16'hf7c2;
  localparam logic [15:0] IIR_ADDR = 16'hf7c4;
  localparam logic [15:0] MOD_ADDR = 16'hf7c6;
  localparam logic [15:0] LSR_ADDR = 16'hf7c8;

  // Mode register fields
  localparam int MOD_LEN_LSB  = 0;
  localparam int MOD_DLAB_BIT = 7;
  localparam int MOD_FEN_BIT  = 8;
  localparam int MOD_RFR_BIT  = 9;
  localparam int MOD_TFR_BIT  = 10;
  localparam int MOD_FTL_LSB  = 14;
  // Bits kept by the mode register; FIFO clears self-clear, 13:11 reserved
  localparam logic [15:0] MOD_KEEP_MASK = 16'hc1ff;
  localparam logic [15:0] MOD_RESET     = 16'h0000;

  // Interrupt enable fields
  localparam int IER_RX_BIT  = 0;
  localparam int IER_TX_BIT  = 1;
  localparam int IER_ERR_BIT = 2;
  localparam logic [2:0] IER_RESET = 3'h0;

  // Interrupt source codes
  localparam logic [2:0] SRC_NONE    = 3'h0;
  localparam logic [2:0] SRC_RX_ERR  = 3'h3;
  localparam logic [2:0] SRC_RX_DATA = 3'h2;
  localparam logic [2:0] SRC_TIMEOUT = 3'h6;
  localparam logic [2:0] SRC_TX_REQ  = 3'h1;
  localparam logic [1:0] FMD_FIFO    = 2'h3;
  localparam logic [1:0] FMD_PLAIN   = 2'h0;
  localparam logic [15:0] IIR_RESET  = 16'h0001;

  // Line status bit positions
  localparam int LSR_DR_BIT   = 0;
  localparam int LSR_OER_BIT  = 1;
  localparam int LSR_PER_BIT  = 2;
  localparam int LSR_FER_BIT  = 3;
  localparam int LSR_BI_BIT   = 4;
  localparam int LSR_THRE_BIT = 5;
  localparam int LSR_TEMT_BIT = 6;

  // Sizes and timing
  localparam int FIFO_DEPTH    = 4;
  localparam int TIMEOUT_CHARS = 4;
  localparam logic [15:0] DIV_RESET = 16'h0000;

  // Transmit holding to shift register hand-off
  typedef enum logic [0:0] {
    TX_IDLE   = 1'b0,
    TX_LOADED = 1'b1
  } tx_state_e;

endpackage

/* File: shared/fifo_link_if.sv */
/*
  Connection between the register block and one of its byte FIFOs.
  Assumes both ends share one clock; cap limits the usable depth.
*/
interface fifo_link_if #(
  parameter int W  = 8,
  parameter int CW = 3
);
  logic          push;
  logic [W-1:0]  push_data;
  logic          pop;
  logic          clear;
  logic [CW-1:0] cap;
  logic [W-1:0]  head;
  logic [CW-1:0] count;
  logic          full;
  logic          empty;

  modport store (input push, push_data, pop, clear, cap,
                 output head, count, full, empty);
  modport user  (output push, push_data, pop, clear, cap,
                 input head, count, full, empty);
endinterface

/* File: core/byte_fifo.sv */
/*
  Small circular FIFO used for both the receive and transmit paths.
  Assumes the user never pops while empty; such pops and pushes into a full
  store without a pop are ignored.
*/
module byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4,
  parameter int CW    = 3
) (
  input  wire logic   clock,
  input  wire logic   srst,
  fifo_link_if.store  link
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] count_q, count_d;
  logic          do_push, do_pop;

  // Full against the current cap so non-FIFO mode behaves as one byte
  assign link.full  = (count_q >= link.cap);
  assign link.empty = (count_q == '0);
  assign link.count = count_q;
  assign link.head  = mem_q[rd_q];

  // Pointer and fill bookkeeping
  always_comb begin
    do_pop  = link.pop && !link.empty;
    do_push = link.push && (!link.full || do_pop);
    wr_d    = wr_q;
    rd_d    = rd_q;
    count_d = count_q;
    if (do_push) begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
    end
    if (do_pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
    end
    if (do_push && !do_pop) begin
      count_d = count_q + CW'(1);
    end else if (do_pop && !do_push) begin
      count_d = count_q - CW'(1);
    end
    if (link.clear) begin
      wr_d    = '0;
      rd_d    = '0;
      count_d = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
    end else begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      count_q <= count_d;
    end
  end

  // Storage has no reset; only written slots are ever read
  always_ff @(posedge clock) begin
    if (do_push && !link.clear) begin
      mem_q[wr_q] <= link.push_data;
    end
  end

  a_fill_bound: assert property (@(posedge clock) disable iff (srst)
    count_q <= CW'(DEPTH)) else $error("fifo count above depth");

endmodule

/* File: test/serial_peer.sv */
/*
  Far-side shifter model: hands received characters in as one-cycle pulses
  and takes transmit characters with a randomly stalling ready.
  Assumes the bench drives it from the falling clock edge.
*/
module serial_peer (
  input  wire logic       clock,
  output logic            rx_valid,
  output logic      [7:0] rx_char,
  output logic            rx_parity_err,
  output logic            rx_framing_err,
  output logic            rx_break,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet lines at time zero
  initial begin
    rx_valid = 1'b0;
    rx_char = 8'h00;
    {rx_break, rx_framing_err, rx_parity_err} = 3'h0;
  end

  // Random stalls keep a character parked in the holding register
  always @(negedge clock) begin
    tx_ready <= ($urandom_range(3) != 0);
  end

  // One character pulse; data line then shows the inverse, not the old value
  task automatic send(input logic [7:0] c, input logic [2:0] err);
    @(negedge clock);
    rx_valid = 1'b1;
    rx_char = c;
    {rx_break, rx_framing_err, rx_parity_err} = err;
    @(negedge clock);
    rx_valid = 1'b0;
    rx_char = ~c;
    {rx_break, rx_framing_err, rx_parity_err} = 3'h0;
  endtask
endmodule

/* File: test/tb_fifo_uart_buffer_and_interrupts.sv */
/*
  Self-checking bench for the UART buffer port and interrupt registers.
  Assumes the serial_peer model on the shifter side and word accesses, except one upper-byte divisor write.
*/
module tb_fifo_uart_buffer_and_interrupts;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] BUF = uart_fifo_pkg::BUF_ADDR;
  localparam logic [15:0] IER = uart_fifo_pkg::IER_ADDR;
  localparam logic [15:0] IIR = uart_fifo_pkg::IIR_ADDR;
  localparam logic [15:0] MOD = uart_fifo_pkg::MOD_ADDR;
  localparam logic [15:0] LSR = uart_fifo_pkg::LSR_ADDR;
  logic        clock     = 1'b0;
  logic        srst      = 1'b1;
  logic [15:0] sfr_addr  = 16'h0000;
  logic [15:0] sfr_wdata = 16'h0000;
  logic        sfr_rd    = 1'b0;
  logic        sfr_wr    = 1'b0;
  logic        sfr_word  = 1'b1;
  logic        char_tick = 1'b0;
  wire logic [15:0] sfr_rdata_q;
  wire logic [15:0] divisor_q;
  wire logic [15:0] mode_q;
  wire logic        rx_valid, rx_parity_err, rx_framing_err, rx_break, tx_ready;
  wire logic [7:0]  rx_char;
  wire logic [7:0]  tx_char_q;
  wire logic        tx_valid_q;
  wire logic        irq_q;
  int          fails       = 0;
  int          checks_done = 0;
  logic [15:0] rd_q[$];
  logic [7:0]  tx_q[$];
  logic [7:0]  c;
  int          i;
  int          k;

  always #2 clock = ~clock;

  uart_buffer_irq dut (.clock(clock), .srst(srst), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
    .sfr_wr(sfr_wr), .sfr_word(sfr_word), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
    .rx_valid(rx_valid), .rx_char(rx_char), .rx_parity_err(rx_parity_err),
    .rx_framing_err(rx_framing_err), .rx_break(rx_break), .char_tick(char_tick),
    .tx_ready(tx_ready), .tx_valid_q(tx_valid_q), .tx_char_q(tx_char_q),
    .divisor_q(divisor_q), .mode_q(mode_q), .irq_q(irq_q));

  serial_peer peer (.clock(clock), .rx_valid(rx_valid), .rx_char(rx_char),
    .rx_parity_err(rx_parity_err), .rx_framing_err(rx_framing_err),
    .rx_break(rx_break), .tx_ready(tx_ready));

  // Count and report one comparison
  task automatic judge(input logic ok, input logic [15:0] act, input logic [15:0] exp);
    checks_done++;
    if (!ok) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic cmp_rd(input logic [15:0] act, input logic [15:0] exp);
    judge(act === exp, act, exp);
  endtask
  task automatic cmp_tx(input logic [7:0] act, input logic [7:0] exp);
    judge(act === exp, {8'h00, act}, {8'h00, exp});
  endtask
  task automatic cmp_flag(input logic act, input logic exp);
    judge(act === exp, {15'h0000, act}, {15'h0000, exp});
  endtask

  // Verdict; every bounded wait ends here too
  task automatic summarize();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One bus cycle, strobe held for exactly one sampling edge
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = ~w;
    @(negedge clock);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    acc(1'b0, a, 16'h0000);
  endtask
  task automatic tick();
    @(negedge clock);
    char_tick = 1'b1;
    @(negedge clock);
    char_tick = 1'b0;
  endtask
  // Bounded wait for the shifter to take every expected character
  task automatic drain();
    for (k = 0; k < 200 && tx_q.size() != 0; k++) @(negedge clock);
    if (tx_q.size() != 0) begin
      fails++;
      summarize();
    end
  endtask

  // Read data is registered, so look just after the read edge
  always @(posedge clock) begin
    if (sfr_rd === 1'b1 && srst === 1'b0) begin
      #1;
      cmp_rd(sfr_rdata_q, rd_q.pop_front());
    end
  end
  // Each accepted character against the oldest write; a stray one always mismatches
  always @(posedge clock) begin
    if (tx_valid_q === 1'b1 && tx_ready === 1'b1) begin
      if (tx_q.size() == 0) begin
        cmp_tx(tx_char_q, ~tx_char_q);
      end else begin
        cmp_tx(tx_char_q, tx_q.pop_front());
      end
    end
  end

  initial begin
    void'($urandom(68));
    repeat (3) @(negedge clock);
    srst = 1'b0;
    rd(IIR, 16'h0001);
    rd(IER, 16'h0000);
    // Clear stale statuses first, enable only afterwards
    rd(LSR, 16'h0060);
    wr(IER, 16'h0001);
    for (i = 0; i < 4; i++) begin
      wr(MOD, 16'(i));
      c = 8'($urandom);
      peer.send(c, 3'h0);
      repeat (3) @(negedge clock);
      cmp_flag(irq_q, 1'b1);
      rd(IIR, 16'h0004);
      rd(BUF, {8'h00, c & (8'hff >> (3 - i))});
      rd(IIR, 16'h0001);
      cmp_flag(irq_q, 1'b0);
    end
    // Each error kind outranks data; the enable rise also raises a request
    wr(IER, 16'h0007);
    for (i = 0; i < 3; i++) begin
      peer.send(8'h15, 3'(1 << i));
      repeat (3) @(negedge clock);
      rd(IIR, 16'h0006);
      rd(LSR, 16'h0061 | 16'(4 << i));
      rd(IIR, 16'h0004);
      rd(BUF, 16'h0015);
    end
    // Second character into a full holding byte is dropped as overrun
    peer.send(8'h21, 3'h0);
    peer.send(8'h22, 3'h0);
    repeat (3) @(negedge clock);
    rd(IIR, 16'h0006);
    rd(LSR, 16'h0063);
    rd(BUF, 16'h0021);
    rd(IIR, 16'h0002);
    rd(IIR, 16'h0001);
    // Divisor lanes, word then upper byte alone; no transmit may appear
    wr(MOD, 16'h0083);
    c = 8'($urandom);
    wr(BUF, {c, 8'h5a});
    sfr_word = 1'b0;
    wr(BUF + 16'h0001, {~c, 8'h00});
    sfr_word = 1'b1;
    rd(BUF, {~c, 8'h5a});
    cmp_rd(divisor_q, {~c, 8'h5a});
    // Transmit at every length, upper byte carries noise
    for (i = 0; i < 4; i++) begin
      wr(MOD, 16'(i));
      c = 8'($urandom);
      tx_q.push_back(c & (8'hff >> (3 - i)));
      wr(BUF, {~c, c});
      drain();
    end
    // FIFO mode burst of four; clear bits must not stick in the mode register
    wr(MOD, 16'h8703);
    cmp_rd(mode_q, 16'h8103);
    for (i = 0; i < 4; i++) begin
      tx_q.push_back(8'h30 + 8'(i));
      wr(BUF, 16'h0030 + 16'(i));
    end
    drain();
    rd(IIR, 16'h00c2);
    rd(IIR, 16'h00c1);
    // Trigger at three bytes, fill to four, drop below, then idle timeout
    wr(IER, 16'h0001);
    for (i = 0; i < 4; i++) begin
      peer.send(8'h40 + 8'(i), 3'h0);
      repeat (3) @(negedge clock);
      rd(IIR, (i >= 2) ? 16'h00c4 : 16'h00c1);
    end
    rd(BUF, 16'h0040);
    rd(IIR, 16'h00c4);
    rd(BUF, 16'h0041);
    rd(IIR, 16'h00c1);
    // Three idle character times are one short of the timeout
    repeat (3) tick();
    rd(IIR, 16'h00c1);
    tick();
    repeat (2) @(negedge clock);
    rd(IIR, 16'h00cc);
    rd(BUF, 16'h0042);
    rd(IIR, 16'h00c1);
    rd(BUF, 16'h0043);
    // Mid-run reset must bring back the identification, enable and mode reset values
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    rd(IIR, 16'h0001);
    rd(IER, 16'h0000);
    rd(MOD, 16'h0000);
    cmp_rd(mode_q, 16'h0000);
    summarize();
  end
endmodule
